// >>> hdl/tx_sched_pkg.sv
// Package for the transmit source scheduler: register map, control word layout,
// timing counts and the carrier types shared by the design and its bench.
// Assumes a 10 MHz register clock and 32-bit AXI4-Lite register access.
package tx_sched_pkg;
  // Clock and fixed timebase; the tick count is rounded up to whole cycles.
  localparam int CLK_PERIOD_NS = 100;
  localparam int FIXED_TICK_NS = 100000;
  localparam logic [15:0] FIXED_TICK_CYC =
    16'((FIXED_TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  // Byte addresses of the register words, 12-bit space.
  localparam int ADDR_W = 12;
  localparam logic [11:0] ADDR_CFG = 12'h000;
  localparam logic [11:0] ADDR_STATUS = 12'h004;
  localparam logic [11:0] ADDR_HI = 12'h008;
  localparam logic [11:0] ADDR_LO = 12'h00C;
  localparam logic [11:0] ADDR_FIFO = 12'h010;
  localparam logic [11:0] ADDR_TB0 = 12'h014;
  localparam logic [11:0] ADDR_TB1 = 12'h018;
  localparam logic [11:0] ADDR_PACE = 12'h01C;
  // Address regions selected by bits 11:10: registers, control array, two data banks.
  localparam logic [1:0] REG_REGION = 2'h0;
  localparam logic [1:0] CTRL_REGION = 2'h1;
  localparam logic [1:0] BANK_A_REGION = 2'h2;
  localparam logic [1:0] BANK_B_REGION = 2'h3;
  // Configuration register fields.
  localparam int CFG_EN_BIT = 0;
  localparam int CFG_MODE_LSB = 1;
  localparam int CFG_SWAP_BIT = 3;
  localparam int CFG_PACE_BIT = 4;
  localparam int CFG_BANK_BIT = 5;
  // Scheduler control word fields; bits 26:24 are read-only status.
  localparam int CW_TYPE_LSB = 0;
  localparam int CW_TB_LSB = 2;
  localparam int CW_PER_BIT = 4;
  localparam int CW_DLY_LSB = 8;
  localparam int CW_DONE_BIT = 24;
  localparam int CW_PEND_BIT = 25;
  localparam int CW_OVR_BIT = 26;
  localparam logic [3:0] LAST_MINOR = 4'hF;
  localparam logic [8:0] FIFO_FULL_CNT = 9'h100;
  // AXI responses.
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    MODE_DEFAULT = 2'b00,
    MODE_FRAME = 2'b01,
    MODE_MAJMIN = 2'b10
  } sched_mode_t;
  typedef enum logic [1:0] {
    ENT_NULL = 2'b00,
    ENT_MASTER = 2'b01,
    ENT_SLAVE = 2'b10
  } entry_kind_t;
  typedef enum logic [2:0] {
    SRC_NONE = 3'b000,
    SRC_HI = 3'b001,
    SRC_SCHED = 3'b010,
    SRC_LO = 3'b011,
    SRC_FIFO = 3'b100
  } tx_src_t;
  // Word handed to the protocol controller, with its origin for diagnostics.
  typedef struct packed {
    logic [31:0] word;
    tx_src_t src;
    logic [7:0] entry;
  } tx_word_t;
endpackage : tx_sched_pkg

// >>> hdl/tx_source_scheduler.sv
// Transmit source arbiter and hardware scheduler for one serial transmit channel.
// Assumes the protocol controller sits on aclk and takes a word on tx_valid and tx_ready.
// Software reaches configuration, sources and scheduler arrays over AXI4-Lite.
//
// The AXI4-Lite register port and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
module tx_source_scheduler (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic awvalid,
  output logic awready,
  input wire logic [tx_sched_pkg::ADDR_W-1:0] awaddr,
  input wire logic [2:0] awprot,
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  input wire logic arvalid,
  output logic arready,
  input wire logic [tx_sched_pkg::ADDR_W-1:0] araddr,
  input wire logic [2:0] arprot,
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  input wire logic tx_ready,
  output logic tx_valid,
  output tx_sched_pkg::tx_word_t tx_out,
  output logic line_oe_n,
  output logic overrun_pulse
);
  import tx_sched_pkg::*;

  typedef struct packed {
    logic en;
    sched_mode_t mode;
    logic swap;
    logic paced;
    logic bank_sel;
    logic bank_act;
    logic [15:0] tb0;
    logic [15:0] tb1;
    logic [15:0] pace;
    logic [15:0] fix_cnt;
    logic [15:0] tb0_cnt;
    logic [15:0] tb1_cnt;
    logic [15:0] pace_cnt;
    logic pace_ok;
    logic [2:0] tick_lat;
    logic [2:0] round_tk;
    logic [3:0] minor_idx;
    logic [7:0] ptr;
    logic grp;
    logic [255:0] wrtn;
    logic [255:0] fresh;
    logic [255:0] spent;
    logic [255:0] pend;
    logic [255:0] done;
    logic [255:0] ovr;
    logic sv;
    logic [31:0] slot_word;
    logic [7:0] slot_idx;
    logic hi_v;
    logic [31:0] hi_word;
    logic lo_v;
    logic [31:0] lo_word;
    logic [7:0] f_wp;
    logic [7:0] f_rp;
    logic [8:0] f_cnt;
    tx_word_t tx;
    logic tx_valid;
    logic overrun_pulse;
    logic line_oe_n;
    logic aw_v;
    logic [ADDR_W-1:0] aw_addr;
    logic w_v;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } state_t;

  state_t state_q;
  state_t state_d;

  // Arrays live outside the state struct so they map onto RAM; none is reset.
  logic [31:0] ctrl_mem [0:255];
  logic [31:0] dat_mem [0:1][0:255];
  logic [15:0] cnt_mem [0:255];
  logic [31:0] fifo_mem [0:255];

  logic ctrl_we;
  logic dat_we;
  logic dat_bank;
  logic fifo_we;
  logic cnt_we;
  logic [15:0] cnt_wd;
  logic [31:0] wr_val;
  logic [7:0] wr_idx;
  logic [7:0] rd_idx;
  logic [7:0] p;
  logic [31:0] cw;
  logic [31:0] old_w;
  logic [15:0] cnt_rd;
  logic [15:0] dly;
  logic [15:0] c1;
  logic [1:0] tb;
  logic [2:0] tick;
  logic [2:0] lat_now;
  logic ticked;
  logic fire;
  logic fifo_ok;
  logic minor_fire;
  logic wr_go;
  logic rd_hit;
  logic ctrl_hit;
  logic inflight;
  tx_src_t src;

  // Byte-lane merge for partial writes.
  function automatic logic [31:0] merge_bytes(input logic [31:0] old_v,
                                              input logic [31:0] new_v,
                                              input logic [3:0] strb);
    logic [31:0] res;
    res = old_v;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[8*i +: 8] = new_v[8*i +: 8];
      end
    end
    return res;
  endfunction : merge_bytes

  // Next-state logic: timebases, arbitration, register writes, the scan, then register reads.
  always_comb begin
    state_d = state_q;
    ctrl_we = 1'b0;
    dat_we = 1'b0;
    fifo_we = 1'b0;
    cnt_we = 1'b0;
    cnt_wd = 16'h0000;
    fire = 1'b0;
    src = SRC_NONE;
    ticked = 1'b0;
    state_d.overrun_pulse = 1'b0;
    wr_idx = state_q.aw_addr[9:2];
    rd_idx = araddr[9:2];
    dat_bank = state_q.aw_addr[10];
    p = state_q.ptr;
    cw = ctrl_mem[p];
    cnt_rd = cnt_mem[p];
    dly = cw[CW_DLY_LSB +: 16];
    tb = cw[CW_TB_LSB +: 2];
    c1 = cnt_rd + 16'h0001;
    // An entry already held in the slot or on offer is never loaded a second time.
    inflight = (state_q.sv && state_q.slot_idx == p) ||
               (state_q.tx_valid && state_q.tx.src == SRC_SCHED && state_q.tx.entry == p);
    tick[0] = (state_q.fix_cnt == FIXED_TICK_CYC - 16'h0001);
    tick[1] = (state_q.tb0_cnt >= state_q.tb0);
    tick[2] = (state_q.tb1_cnt >= state_q.tb1);
    state_d.fix_cnt = tick[0] ? 16'h0000 : state_q.fix_cnt + 16'h0001;
    state_d.tb0_cnt = tick[1] ? 16'h0000 : state_q.tb0_cnt + 16'h0001;
    state_d.tb1_cnt = tick[2] ? 16'h0000 : state_q.tb1_cnt + 16'h0001;
    lat_now = state_q.tick_lat | tick;
    // Ticks are gathered per scan round so every entry of a round sees the same tick.
    if (state_q.ptr == 8'hFF) begin
      state_d.round_tk = lat_now;
      state_d.tick_lat = 3'h0;
      if (lat_now[2]) begin
        state_d.minor_idx = 4'h0;
        state_d.bank_act = (state_q.mode == MODE_MAJMIN) ? state_q.bank_sel : 1'b0;
      end else if (lat_now[0] && state_q.minor_idx != LAST_MINOR) begin
        state_d.minor_idx = state_q.minor_idx + 4'h1;
      end
    end else begin
      state_d.tick_lat = lat_now;
    end
    minor_fire = state_q.round_tk[0] | state_q.round_tk[2];

    if (state_q.tx_valid && tx_ready) begin
      state_d.tx_valid = 1'b0;
    end
    fifo_ok = (state_q.f_cnt != 9'h000) && (!state_q.paced || state_q.pace_ok);
    if (!state_q.tx_valid && state_q.en) begin
      if (state_q.hi_v) begin
        src = SRC_HI;
      end else if (!state_q.swap && state_q.sv) begin
        src = SRC_SCHED;
      end else if (state_q.swap && fifo_ok) begin
        src = SRC_FIFO;
      end else if (state_q.swap && state_q.sv) begin
        src = SRC_SCHED;
      end else if (state_q.lo_v) begin
        src = SRC_LO;
      end else if (!state_q.swap && fifo_ok) begin
        src = SRC_FIFO;
      end
    end
    case (src)
      SRC_HI: begin
        state_d.tx = '{word: state_q.hi_word, src: SRC_HI, entry: 8'h00};
        state_d.hi_v = 1'b0;
      end
      SRC_LO: begin
        state_d.tx = '{word: state_q.lo_word, src: SRC_LO, entry: 8'h00};
        state_d.lo_v = 1'b0;
      end
      SRC_SCHED: begin
        state_d.tx = '{word: state_q.slot_word, src: SRC_SCHED, entry: state_q.slot_idx};
        state_d.sv = 1'b0;
      end
      SRC_FIFO: begin
        state_d.tx = '{word: fifo_mem[state_q.f_rp], src: SRC_FIFO, entry: 8'h00};
        state_d.f_rp = state_q.f_rp + 8'h01;
        state_d.pace_ok = 1'b0;
      end
      default: begin
      end
    endcase
    if (src != SRC_NONE) begin
      state_d.tx_valid = 1'b1;
    end
    if (state_q.pace_cnt >= state_q.pace) begin
      state_d.pace_cnt = 16'h0000;
      state_d.pace_ok = 1'b1;
    end else begin
      state_d.pace_cnt = state_q.pace_cnt + 16'h0001;
    end

    // AXI write: address and data are taken in either order, answered together.
    if (awvalid && state_q.awready) begin
      state_d.aw_v = 1'b1;
      state_d.aw_addr = awaddr;
    end
    if (wvalid && state_q.wready) begin
      state_d.w_v = 1'b1;
      state_d.w_data = wdata;
      state_d.w_strb = wstrb;
    end
    if (state_q.bvalid && bready) begin
      state_d.bvalid = 1'b0;
    end
    wr_go = state_q.aw_v && state_q.w_v && !state_q.bvalid;
    case (state_q.aw_addr[11:10])
      CTRL_REGION: old_w = ctrl_mem[wr_idx];
      BANK_A_REGION, BANK_B_REGION: old_w = dat_mem[dat_bank][wr_idx];
      default: begin
        case (state_q.aw_addr)
          ADDR_CFG: old_w = {26'h0, state_q.bank_sel, state_q.paced, state_q.swap,
                             state_q.mode, state_q.en};
          ADDR_HI: old_w = state_q.hi_word;
          ADDR_LO: old_w = state_q.lo_word;
          ADDR_TB0: old_w = {16'h0000, state_q.tb0};
          ADDR_TB1: old_w = {16'h0000, state_q.tb1};
          ADDR_PACE: old_w = {16'h0000, state_q.pace};
          default: old_w = 32'h0000_0000;
        endcase
      end
    endcase
    wr_val = merge_bytes(old_w, state_q.w_data, state_q.w_strb);
    ctrl_hit = wr_go && (state_q.aw_addr[11:10] == CTRL_REGION);
    if (wr_go) begin
      state_d.aw_v = 1'b0;
      state_d.w_v = 1'b0;
      state_d.bvalid = 1'b1;
      state_d.bresp = RESP_OKAY;
      case (state_q.aw_addr[11:10])
        CTRL_REGION: begin
          ctrl_we = 1'b1;
          state_d.wrtn[wr_idx] = 1'b1;
          state_d.fresh[wr_idx] = 1'b1;
          state_d.done[wr_idx] = 1'b0;
          state_d.ovr[wr_idx] = 1'b0;
        end
        BANK_A_REGION, BANK_B_REGION: dat_we = 1'b1;
        default: begin
          case (state_q.aw_addr)
            ADDR_CFG: begin
              state_d.en = wr_val[CFG_EN_BIT];
              state_d.mode = sched_mode_t'(wr_val[CFG_MODE_LSB +: 2]);
              state_d.swap = wr_val[CFG_SWAP_BIT];
              state_d.paced = wr_val[CFG_PACE_BIT];
              state_d.bank_sel = wr_val[CFG_BANK_BIT];
            end
            ADDR_HI: begin
              state_d.hi_word = wr_val;
              state_d.hi_v = 1'b1;
            end
            ADDR_LO: begin
              state_d.lo_word = wr_val;
              state_d.lo_v = 1'b1;
            end
            ADDR_FIFO: begin
              // A push into a full FIFO is dropped; status shows full.
              if (state_q.f_cnt != FIFO_FULL_CNT) begin
                fifo_we = 1'b1;
                state_d.f_wp = state_q.f_wp + 8'h01;
              end
            end
            ADDR_TB0: state_d.tb0 = wr_val[15:0];
            ADDR_TB1: state_d.tb1 = wr_val[15:0];
            ADDR_PACE: state_d.pace = wr_val[15:0];
            ADDR_STATUS: begin
            end
            default: state_d.bresp = RESP_SLVERR;
          endcase
        end
      endcase
    end
    state_d.f_cnt = state_q.f_cnt + {8'h00, fifo_we} - {8'h00, src == SRC_FIFO};

    // Status follows the controller taking the word, not the grant, so a stalled word stays pending.
    // complete on send
    if (state_q.tx_valid && tx_ready && state_q.tx.src == SRC_SCHED) begin
      state_d.done[state_q.tx.entry] = 1'b1;
      state_d.pend[state_q.tx.entry] = 1'b0;
    end

    // Scheduler scan: one entry per cycle, a full round every 256 cycles.
    // control and data share an index
    if (!state_q.en || state_q.fresh[p]) begin
      cnt_we = 1'b1;
      cnt_wd = dly;
      if (!(ctrl_hit && wr_idx == p)) begin
        state_d.fresh[p] = 1'b0;
      end
      state_d.spent[p] = 1'b0;
      state_d.grp = 1'b0;
    end else if (!state_q.wrtn[p] || cw[CW_TYPE_LSB +: 2] == ENT_NULL) begin
      state_d.grp = 1'b0;
    end else if (tb == 2'h0) begin
      state_d.grp = state_q.grp;
    end else if (state_q.mode == MODE_MAJMIN) begin
      fire = minor_fire && dly[state_q.minor_idx] && !state_q.spent[p];
    end else if (cw[CW_TYPE_LSB +: 2] == ENT_MASTER) begin
      ticked = state_q.round_tk[tb - 2'h1];
      if (ticked && !state_q.spent[p]) begin
        cnt_we = 1'b1;
        if (cnt_rd <= 16'h0001) begin
          fire = 1'b1;
          cnt_wd = dly;
        end else begin
          cnt_wd = cnt_rd - 16'h0001;
        end
      end
      state_d.grp = fire;
    end else if (cw[CW_TYPE_LSB +: 2] == ENT_SLAVE && state_q.grp && !state_q.spent[p]) begin
      if (state_q.mode == MODE_FRAME) begin
        cnt_we = 1'b1;
        if (dly <= 16'h0001 || c1 >= dly) begin
          fire = 1'b1;
          cnt_wd = 16'h0000;
        end else begin
          cnt_wd = c1;
        end
      end else begin
        fire = 1'b1;
      end
    end
    if (fire) begin
      if (!cw[CW_PER_BIT]) begin
        state_d.spent[p] = 1'b1;
      end
      if (state_q.pend[p] && cw[CW_PER_BIT]) begin
        state_d.ovr[p] = 1'b1;
        state_d.overrun_pulse = 1'b1;
      end
      state_d.pend[p] = 1'b1;
    end
    // The slot refills in the cycle it is granted, so a slave right behind its master is not starved.
    if (!state_d.sv && state_q.en && (state_q.pend[p] || fire) && !inflight) begin
      state_d.sv = 1'b1;
      state_d.slot_word = dat_mem[state_q.bank_act][p];
      state_d.slot_idx = p;
    end
    state_d.ptr = state_q.ptr + 8'h01;

    // AXI read: one outstanding read, answered the cycle after the address.
    if (state_q.rvalid && rready) begin
      state_d.rvalid = 1'b0;
    end
    rd_hit = 1'b1;
    case (araddr[11:10])
      CTRL_REGION: begin
        state_d.rdata = 32'h0000_0000;
        if (state_q.wrtn[rd_idx]) begin
          state_d.rdata = ctrl_mem[rd_idx];
        end
        state_d.rdata[31:24] = 8'h00;
        state_d.rdata[CW_DONE_BIT] = state_q.done[rd_idx];
        state_d.rdata[CW_PEND_BIT] = state_q.pend[rd_idx];
        state_d.rdata[CW_OVR_BIT] = state_q.ovr[rd_idx];
      end
      BANK_A_REGION, BANK_B_REGION: state_d.rdata = dat_mem[araddr[10]][rd_idx];
      default: begin
        case (araddr)
          ADDR_CFG: state_d.rdata = {26'h0, state_q.bank_sel, state_q.paced, state_q.swap,
                                     state_q.mode, state_q.en};
          ADDR_STATUS: state_d.rdata = {15'h0, state_q.f_cnt, 2'h0, state_q.tx_valid,
                                        state_q.lo_v, state_q.hi_v,
                                        state_q.f_cnt == FIFO_FULL_CNT,
                                        state_q.f_cnt == 9'h000, state_q.bank_act};
          ADDR_HI: state_d.rdata = state_q.hi_word;
          ADDR_LO: state_d.rdata = state_q.lo_word;
          ADDR_TB0: state_d.rdata = {16'h0000, state_q.tb0};
          ADDR_TB1: state_d.rdata = {16'h0000, state_q.tb1};
          ADDR_PACE: state_d.rdata = {16'h0000, state_q.pace};
          ADDR_FIFO: state_d.rdata = 32'h0000_0000;
          default: begin
            state_d.rdata = 32'h0000_0000;
            rd_hit = 1'b0;
          end
        endcase
      end
    endcase
    if (arvalid && state_q.arready) begin
      state_d.rvalid = 1'b1;
      state_d.rresp = rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else begin
      state_d.rdata = state_q.rdata;
    end
    state_d.arready = !state_d.rvalid;
    state_d.awready = !state_d.aw_v;
    state_d.wready = !state_d.w_v;
    state_d.line_oe_n = !state_d.en;
  end

  // State register; reset parks the line undriven and clears every source.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_q <= '0;
      state_q.line_oe_n <= 1'b1;
    end else begin
      state_q <= state_d;
    end
  end

  // Array write ports, one writer each.
  always_ff @(posedge aclk) begin
    if (ctrl_we) begin
      ctrl_mem[wr_idx] <= wr_val;
    end
    if (dat_we) begin
      dat_mem[dat_bank][wr_idx] <= wr_val;
    end
    if (fifo_we) begin
      fifo_mem[state_q.f_wp] <= wr_val;
    end
    if (cnt_we) begin
      cnt_mem[state_q.ptr] <= cnt_wd;
    end
  end

  // Outputs straight from the state register.
  assign awready = state_q.awready;
  assign wready = state_q.wready;
  assign bvalid = state_q.bvalid;
  assign bresp = state_q.bresp;
  assign arready = state_q.arready;
  assign rvalid = state_q.rvalid;
  assign rdata = state_q.rdata;
  assign rresp = state_q.rresp;
  assign tx_valid = state_q.tx_valid;
  assign tx_out = state_q.tx;
  assign line_oe_n = state_q.line_oe_n;
  assign overrun_pulse = state_q.overrun_pulse;
endmodule : tx_source_scheduler

// >>> sim/tx_sink_model.sv
// Model of the protocol controller that takes words from the source arbiter.
// Assumes the same clock; mode 0 takes at once, 1 every fourth cycle, 2 stalls.
`timescale 1ns/1ps
module tx_sink_model (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [1:0] mode,
  output logic tx_ready
);
  logic [1:0] cnt_q;
  // Ready is registered and ignores the offer, so it never depends on tx_valid in the same cycle.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_q <= 2'h0;
      tx_ready <= 1'b0;
    end else begin
      cnt_q <= cnt_q + 2'h1;
      tx_ready <= (mode == 2'h0) || (mode == 2'h1 && cnt_q == 2'h3);
    end
  end
endmodule : tx_sink_model

// >>> sim/tx_sched_sva.sv
// Checker for the transmit source scheduler ports.
// Assumes one clock domain and the synchronous active-low reset.
`timescale 1ns/1ps
module tx_sched_sva (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic rvalid,
  input wire logic rready,
  input wire logic bvalid,
  input wire logic bready,
  input wire logic tx_ready,
  input wire logic tx_valid,
  input wire tx_sched_pkg::tx_word_t tx_out,
  input wire logic line_oe_n,
  input wire logic overrun_pulse
);
  import tx_sched_pkg::*;
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  // Line stays released as reset lets go, and words leave only on a driven line.
  a_oe_reset: assert property ($rose(aresetn) |-> line_oe_n)
    else $error("line driven at reset release");
  a_oe_send: assert property (tx_valid && tx_ready |-> !line_oe_n)
    else $error("word sent on released line");
  // One grant per word: the offer holds until taken, then drops.
  a_tx_hold: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_out))
    else $error("offered word changed");
  a_tx_gap: assert property (tx_valid && tx_ready |=> !tx_valid)
    else $error("offer kept after acceptance");
  a_src_known: assert property (tx_valid |-> tx_out.src inside {[SRC_HI:SRC_FIFO]})
    else $error("word without a source");
  a_ovr_pulse: assert property (overrun_pulse |=> !overrun_pulse)
    else $error("overrun event longer than one cycle");
  // Bus answers: one cycle after a read is taken, cleared when accepted.
  a_r_answer: assert property (arvalid && arready |=> rvalid)
    else $error("read answer late");
  a_ar_block: assert property (rvalid |-> !arready)
    else $error("read taken while answer pending");
  a_r_done: assert property (rvalid && rready |=> !rvalid)
    else $error("read answer kept");
  a_b_done: assert property (bvalid && bready |=> !bvalid)
    else $error("write answer kept");
  c_hi: cover property (tx_valid && tx_ready && tx_out.src == SRC_HI);
  c_sched: cover property (tx_valid && tx_ready && tx_out.src == SRC_SCHED);
  c_ovr: cover property (overrun_pulse);
endmodule : tx_sched_sva
bind tx_source_scheduler tx_sched_sva i_sva (.aclk, .aresetn, .arvalid, .arready, .rvalid,
  .rready, .bvalid, .bready, .tx_ready, .tx_valid, .tx_out, .line_oe_n, .overrun_pulse);

// >>> sim/tx_source_scheduler_test.sv
// Testbench for the transmit source scheduler over AXI4-Lite.
// Assumes a 10 MHz clock and the sink model on the transmit side.
`timescale 1ns/1ps
module tx_source_scheduler_test;
  import tx_sched_pkg::*;
  logic aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0, awready, wready, bvalid, arready, rvalid;
  logic tx_ready, tx_valid, line_oe_n, overrun_pulse;
  logic [11:0] awaddr = 12'h000, araddr = 12'h000;
  logic [2:0] awprot = 3'h0, arprot = 3'h0;
  logic [31:0] wdata = 32'h0, rdata;
  logic [3:0] wstrb = 4'hF;
  logic [1:0] bresp, rresp, mode = 2'h0;
  tx_word_t tx_out;
  tx_word_t q[$];
  int fail_count = 0, check_count = 0;
  always #50 aclk = ~aclk;
  tx_source_scheduler i_dut (.aclk, .aresetn, .awvalid, .awready, .awaddr, .awprot, .wvalid,
    .wready, .wdata, .wstrb, .bvalid, .bready, .bresp, .arvalid, .arready, .araddr, .arprot,
    .rvalid, .rready, .rdata, .rresp, .tx_ready, .tx_valid, .tx_out, .line_oe_n, .overrun_pulse);
  tx_sink_model i_sink (.aclk, .aresetn, .mode, .tx_ready);
  // Handshakes are sampled mid-cycle, where registered signals have settled.
  always @(negedge aclk) if (tx_valid === 1'b1 && tx_ready === 1'b1) q.push_back(tx_out);
  task conclude;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : conclude
  task chk(input logic [42:0] g, input logic [42:0] e);
    check_count++;
    if (g !== e) begin
      fail_count++;
      $display("ERROR t=%0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  task wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
    logic ta, tw, tb;
    @(posedge aclk);
    {awaddr, wdata, awvalid, wvalid, bready} <= {a, d, 3'h7};
    do begin
      @(negedge aclk);
      ta = awvalid & awready;
      tw = wvalid & wready;
      tb = bvalid;
      if (tb) chk({41'h0, bresp}, {41'h0, er});
      @(posedge aclk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
    end while (!tb);
    bready <= 1'b0;
  endtask : wr
  task rd(input logic [11:0] a, input logic [31:0] ed, input logic [1:0] er);
    logic ta, tr;
    @(posedge aclk);
    {araddr, arvalid, rready} <= {a, 2'h3};
    do begin
      @(negedge aclk);
      ta = arvalid & arready;
      tr = rvalid;
      if (tr) chk({9'h0, rresp, rdata}, {9'h0, er, ed});
      @(posedge aclk);
      if (ta) arvalid <= 1'b0;
    end while (!tr);
    rready <= 1'b0;
  endtask : rd
  // The entry index only means something for scheduler words.
  task expect_tx(input tx_src_t s, input logic [7:0] e, input logic [31:0] w);
    tx_word_t g;
    while (q.size() == 0) @(negedge aclk);
    g = q.pop_front();
    chk({g.src, (s == SRC_SCHED) ? g.entry : e, g.word}, {s, e, w});
  endtask : expect_tx
  // A hang ends the run as a mismatch.
  initial begin
    #(50000 * 100);
    fail_count++;
    conclude();
  end
  // Main sequence: reset, bus errors, ranking, swap, schedule, overrun.
  initial begin
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    @(negedge aclk);
    chk({42'h0, line_oe_n}, 43'h1);
    rd(ADDR_CFG, 32'h0, RESP_OKAY);
    rd(12'h020, 32'h0, RESP_SLVERR);
    wr(12'h024, 32'h1, RESP_SLVERR);
    mode <= 2'h1;
    wr(ADDR_LO, 32'h0A11, RESP_OKAY);
    wr(ADDR_FIFO, 32'h0F11, RESP_OKAY);
    wr(ADDR_HI, 32'h0B11, RESP_OKAY);
    repeat (20) @(negedge aclk);
    chk(43'(q.size()), 43'h0);
    wr(ADDR_CFG, 32'h1, RESP_OKAY);
    expect_tx(SRC_HI, 8'h00, 32'h0B11);
    chk({42'h0, line_oe_n}, 43'h0);
    expect_tx(SRC_LO, 8'h00, 32'h0A11);
    expect_tx(SRC_FIFO, 8'h00, 32'h0F11);
    wr(ADDR_CFG, 32'h0, RESP_OKAY);
    mode <= 2'h0;
    wr(ADDR_FIFO, 32'h0F22, RESP_OKAY);
    wr(ADDR_LO, 32'h0A22, RESP_OKAY);
    wr(ADDR_CFG, 32'h9, RESP_OKAY);
    expect_tx(SRC_FIFO, 8'h00, 32'h0F22);
    expect_tx(SRC_LO, 8'h00, 32'h0A22);
    wr(ADDR_CFG, 32'h0, RESP_OKAY);
    wr(ADDR_TB0, 32'h3, RESP_OKAY);
    wr(12'h800, 32'hD000, RESP_OKAY);
    wr(12'h804, 32'hD001, RESP_OKAY);
    wr(12'h400, 32'h0209, RESP_OKAY);
    wr(12'h404, 32'h000A, RESP_OKAY);
    wr(ADDR_CFG, 32'h1, RESP_OKAY);
    expect_tx(SRC_SCHED, 8'h00, 32'hD000);
    expect_tx(SRC_SCHED, 8'h01, 32'hD001);
    rd(12'h400, 32'h0100_0209, RESP_OKAY);
    wr(12'h400, 32'h0201, RESP_OKAY);
    rd(12'h400, 32'h0201, RESP_OKAY);
    wr(ADDR_CFG, 32'h3, RESP_OKAY);
    wr(12'h808, 32'hD002, RESP_OKAY);
    wr(12'h80C, 32'hD003, RESP_OKAY);
    wr(12'h40C, 32'h021E, RESP_OKAY);
    wr(12'h408, 32'h011D, RESP_OKAY);
    expect_tx(SRC_SCHED, 8'h02, 32'hD002);
    expect_tx(SRC_SCHED, 8'h03, 32'hD003);
    expect_tx(SRC_SCHED, 8'h02, 32'hD002);
    expect_tx(SRC_SCHED, 8'h02, 32'hD002);
    expect_tx(SRC_SCHED, 8'h03, 32'hD003);
    wr(12'h408, 32'h0, RESP_OKAY);
    wr(ADDR_CFG, 32'h1, RESP_OKAY);
    repeat (8) @(negedge aclk);
    q.delete();
    wr(12'h404, 32'h0, RESP_OKAY);
    mode <= 2'h2;
    wr(12'h400, 32'h0119, RESP_OKAY);
    while (overrun_pulse !== 1'b1) @(negedge aclk);
    rd(12'h400, 32'h0600_0119, RESP_OKAY);
    mode <= 2'h0;
    expect_tx(SRC_SCHED, 8'h00, 32'hD000);
    conclude();
  end
endmodule : tx_source_scheduler_test
